// ==== rtl/ssar_pkg.sv ====
// Notes on behaviour
// - full conversion takes sixteen serial clock cycles
// - frame select may rise early, short cycling
// - sample input at start, isolate while converting
// - shift current result out, MSB first
// - frame held low restarts conversions back to back
// - result is 12-bit two's complement
// - data output driven only while frame low
// - frame from select fall to select rise
// - three acquisition cycles, then thirteen converting
// - falls 1-4 zeros, 5-16 result bits
// - continuous mode wraps every sixteen edges
// - select falls, clock high: wait first fall
// - select falls, clock low: counts as fall
// - simultaneous fall enters acquisition at once
// - each data bit launched on clock fall
// - early select rise aborts, output released
package ssar_pkg;
  // result word width, two's complement
  localparam int RESULT_W = 12;
  // falling edges in one conversion
  localparam logic [4:0] EDGES_PER_CONV = 5'h10;
  // last falling edge of the zero preamble; conversion begins here
  localparam logic [4:0] ZERO_EDGES = 5'h04;
  // first falling edge of a conversion
  localparam logic [4:0] FIRST_EDGE = 5'h01;
  // edge counter reset value
  localparam logic [4:0] EDGE_CNT_RST = 5'h00;
  // held result reset value
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  // data pin level while nothing is shifted
  localparam logic DOUT_RST = 1'b0;
  // buffer entries
  localparam int BUF_DEPTH = 2;
  // buffer occupancy reset value
  localparam logic [1:0] BUF_CNT_RST = 2'h0;
  // buffer occupancy when full
  localparam logic [1:0] BUF_CNT_FULL = 2'h2;

  // sequencer states
  typedef enum logic [1:0] {
    SSAR_IDLE,
    SSAR_ARMED,
    SSAR_ACQ,
    SSAR_CONV
  } ssar_state_t;
endpackage

// ==== rtl/ssar_buf_if.sv ====
`timescale 1ns/1ps
// carries result words from the sample port to the sequencer
interface ssar_buf_if;
  // filling side
  logic [ssar_pkg::RESULT_W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  // draining side
  logic [ssar_pkg::RESULT_W-1:0] out_data;
  logic out_valid;
  logic out_ready;

  // the buffer itself
  modport store (
    input in_data, in_valid, out_ready,
    output in_ready, out_data, out_valid
  );
  // the sequencer that fills and drains it
  modport user (
    output in_data, in_valid, out_ready,
    input in_ready, out_data, out_valid
  );
endinterface

// ==== rtl/ssar_buf.sv ====
`timescale 1ns/1ps
// two-entry word buffer, flip-flop storage
module ssar_buf (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // word path
  ssar_buf_if.store bif
);
  // storage and pointers
  logic [ssar_pkg::RESULT_W-1:0] mem_r [ssar_pkg::BUF_DEPTH];
  logic [ssar_pkg::RESULT_W-1:0] mem_nxt [ssar_pkg::BUF_DEPTH];
  logic wr_ptr_r, wr_ptr_nxt;
  logic rd_ptr_r, rd_ptr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  // ready is registered so the sample port sees a flop
  logic ready_r, ready_nxt;
  logic push, pop;

  assign bif.in_ready = ready_r;
  assign bif.out_valid = (cnt_r != ssar_pkg::BUF_CNT_RST);
  assign bif.out_data = mem_r[rd_ptr_r];

  // next pointers, occupancy and storage
  always_comb begin
    push = bif.in_valid && ready_r;
    pop = bif.out_ready && (cnt_r != ssar_pkg::BUF_CNT_RST);
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    // write a new word at the tail
    if (push) begin
      mem_nxt[wr_ptr_r] = bif.in_data;
      wr_ptr_nxt = ~wr_ptr_r;
    end
    // drop the head word
    if (pop) begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    // occupancy moves only when exactly one side acts
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
    ready_nxt = (cnt_nxt != ssar_pkg::BUF_CNT_FULL);
  end

  // state registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_r <= '{default: ssar_pkg::RESULT_RST};
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= ssar_pkg::BUF_CNT_RST;
      ready_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end
endmodule

// ==== rtl/ssar_readout.sv ====
`timescale 1ns/1ps
// conversion sequencer and serial readout of the converter
module ssar_readout (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link pins from the host
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  // serial data pin, split into level and enable
  output logic dout_o,
  output logic dout_oe,
  // result words from the conversion core
  input wire logic [ssar_pkg::RESULT_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  // sequencer status
  output logic track_o,
  output logic converting_o,
  output logic conv_done_o,
  output logic conv_abort_o,
  output logic underrun_o
);
  // two-stage synchronisers plus one stage for edge detection
  logic cs_n_s1_r, cs_n_s2_r, cs_n_s3_r;
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  // edge strobes taken from the settled stages only
  logic cs_fall, cs_rise, sclk_fall;

  // sequencer state
  ssar_pkg::ssar_state_t state_r, state_nxt;
  // falling edges seen in the current conversion
  logic [4:0] edge_cnt_r, edge_cnt_nxt;
  // result held for the conversion in progress
  logic [ssar_pkg::RESULT_W-1:0] hold_r, hold_nxt;
  // output flops
  logic dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic track_r, track_nxt;
  logic conv_r, conv_nxt;
  logic done_r, done_nxt;
  logic abort_r, abort_nxt;
  logic under_r, under_nxt;
  // take the head word of the buffer
  logic take;

  // buffer between the core and the shifter
  ssar_buf_if bif ();

  ssar_buf ssar_buf_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .bif(bif)
  );

  assign bif.in_data = sample_data;
  assign bif.in_valid = sample_valid;
  assign bif.out_ready = take;
  assign sample_ready = bif.in_ready;

  assign dout_o = dout_r;
  assign dout_oe = oe_r;
  assign track_o = track_r;
  assign converting_o = conv_r;
  assign conv_done_o = done_r;
  assign conv_abort_o = abort_r;
  assign underrun_o = under_r;

  // bit presented on a given falling edge: zeros first, then MSB down
  function automatic logic edge_bit(input logic [ssar_pkg::RESULT_W-1:0] word,
                                    input logic [4:0] edge_no);
    logic [4:0] idx;
    idx = ssar_pkg::EDGES_PER_CONV - edge_no;
    if (edge_no <= ssar_pkg::ZERO_EDGES) begin
      edge_bit = 1'b0;
    end else begin
      edge_bit = word[idx[3:0]];
    end
  endfunction

  // pin synchronisers; the host clock is sampled, never used as a clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_n_s1_r <= 1'b1;
      cs_n_s2_r <= 1'b1;
      cs_n_s3_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
    end else begin
      cs_n_s1_r <= cs_n_pin;
      cs_n_s2_r <= cs_n_s1_r;
      cs_n_s3_r <= cs_n_s2_r;
      sclk_s1_r <= sclk_pin;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  // edge strobes, one clk cycle each
  always_comb begin
    cs_fall = cs_n_s3_r && !cs_n_s2_r;
    cs_rise = !cs_n_s3_r && cs_n_s2_r;
    sclk_fall = sclk_s3_r && !sclk_s2_r;
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    edge_cnt_nxt = edge_cnt_r;
    hold_nxt = hold_r;
    dout_nxt = dout_r;
    track_nxt = track_r;
    conv_nxt = conv_r;
    done_nxt = 1'b0;
    abort_nxt = 1'b0;
    under_nxt = 1'b0;
    take = 1'b0;
    // frame select is the output enable, tracked with no extra delay
    oe_nxt = !cs_n_s2_r;
    if (cs_n_s2_r) begin
      // frame closed; an open conversion is dropped
      if (cs_rise && (state_r == ssar_pkg::SSAR_ACQ || state_r == ssar_pkg::SSAR_CONV)) begin
        abort_nxt = 1'b1;
      end
      state_nxt = ssar_pkg::SSAR_IDLE;
      edge_cnt_nxt = ssar_pkg::EDGE_CNT_RST;
      dout_nxt = ssar_pkg::DOUT_RST;
      track_nxt = 1'b0;
      conv_nxt = 1'b0;
    end else if (cs_fall) begin
      // frame opens; the clock level decides where counting starts
      if (!sclk_s2_r) begin
        // clock already low, or falling together: this is edge one
        state_nxt = ssar_pkg::SSAR_ACQ;
        edge_cnt_nxt = ssar_pkg::FIRST_EDGE;
        dout_nxt = 1'b0;
        track_nxt = 1'b1;
      end else begin
        // clock high: wait for its first fall
        state_nxt = ssar_pkg::SSAR_ARMED;
        edge_cnt_nxt = ssar_pkg::EDGE_CNT_RST;
        dout_nxt = 1'b0;
      end
      conv_nxt = 1'b0;
    end else if (sclk_fall && state_r != ssar_pkg::SSAR_IDLE) begin
      // every data change happens on a host clock fall
      edge_cnt_nxt = edge_cnt_r + 5'h01;
      case (state_r)
        ssar_pkg::SSAR_ARMED: begin
          // first fall of a conversion, also the wrap in continuous frames
          state_nxt = ssar_pkg::SSAR_ACQ;
          track_nxt = 1'b1;
          conv_nxt = 1'b0;
        end
        ssar_pkg::SSAR_ACQ: begin
          if (edge_cnt_nxt == ssar_pkg::ZERO_EDGES) begin
            // acquisition over: freeze the sample, isolate the input
            state_nxt = ssar_pkg::SSAR_CONV;
            track_nxt = 1'b0;
            conv_nxt = 1'b1;
            take = 1'b1;
            if (bif.out_valid) begin
              hold_nxt = bif.out_data;
            end else begin
              // no fresh word: the last one is repeated and flagged
              under_nxt = 1'b1;
            end
          end
        end
        ssar_pkg::SSAR_CONV: begin
          if (edge_cnt_nxt == ssar_pkg::EDGES_PER_CONV) begin
            // LSB goes out now; next fall starts a new conversion
            state_nxt = ssar_pkg::SSAR_ARMED;
            edge_cnt_nxt = ssar_pkg::EDGE_CNT_RST;
            done_nxt = 1'b1;
          end
        end
        default: begin
          state_nxt = ssar_pkg::SSAR_IDLE;
        end
      endcase
      // the bit is chosen by the edge number just reached
      dout_nxt = edge_bit(hold_nxt, edge_cnt_r + 5'h01);
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ssar_pkg::SSAR_IDLE;
      edge_cnt_r <= ssar_pkg::EDGE_CNT_RST;
      hold_r <= ssar_pkg::RESULT_RST;
      dout_r <= ssar_pkg::DOUT_RST;
      oe_r <= 1'b0;
      track_r <= 1'b0;
      conv_r <= 1'b0;
      done_r <= 1'b0;
      abort_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      hold_r <= hold_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      track_r <= track_nxt;
      conv_r <= conv_nxt;
      done_r <= done_nxt;
      abort_r <= abort_nxt;
      under_r <= under_nxt;
    end
  end
endmodule

// ==== bench/ssar_readout_properties.sv ====
`timescale 1ns/1ps
// watches the readout from its pins only
module ssar_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic dout_o,
  input wire logic dout_oe,
  // sample port
  input wire logic [ssar_pkg::RESULT_W-1:0] sample_data,
  input wire logic sample_valid,
  input wire logic sample_ready,
  // status
  input wire logic track_o,
  input wire logic converting_o,
  input wire logic conv_done_o,
  input wire logic conv_abort_o,
  input wire logic underrun_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // six samples cover sync plus register delay
  property p_oe_off; cs_n_pin [*6] |-> !dout_oe; endproperty
  property p_oe_on; !cs_n_pin [*6] |-> dout_oe; endproperty
  property p_idle; cs_n_pin [*6] |-> !track_o && !converting_o; endproperty
  property p_done_once; conv_done_o |=> !conv_done_o; endproperty
  property p_done_conv; conv_done_o |-> converting_o && dout_oe; endproperty
  property p_excl; !(track_o && converting_o); endproperty
  property p_abort; conv_abort_o |-> $past(cs_n_pin, 2) ##[0:2] !dout_oe; endproperty
  property p_acq_zero; track_o |-> !dout_o; endproperty
  // a new bit lands only while the link clock is low
  property p_launch; $changed(dout_o) && dout_oe |-> !sclk_pin; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven when idle");
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  a_idle: assert property (p_idle) else $error("busy outside frame");
  a_done_once: assert property (p_done_once) else $error("done too long");
  a_done_conv: assert property (p_done_conv) else $error("done out of place");
  a_excl: assert property (p_excl) else $error("track and convert");
  a_abort: assert property (p_abort) else $error("bad abort");
  a_acq_zero: assert property (p_acq_zero) else $error("data in acquisition");
  a_launch: assert property (p_launch) else $error("bit not on fall");
  c_done: cover property (conv_done_o);
  c_abort: cover property (conv_abort_o);
  c_under: cover property (underrun_o);
endmodule

// ==== bench/ssar_host.sv ====
`timescale 1ns/1ps
// host side: frames, link clock, capture
module ssar_host (
  // system clock, only to track the wire
  input wire logic clk,
  // link pins
  output logic cs_n,
  output logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe
);
  logic last_r; // last driven level
  logic rx; // level on the wire
  logic bits[$]; // captured bits, oldest first
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  // released wire shows the inverse, never a stale copy
  always @(posedge clk) if (dout_oe) last_r <= dout_o;
  assign rx = dout_oe ? dout_o : ~last_r;
  // n falls; md 0 clock idles high, 1 low, 2 falls with select
  task automatic frame(input int n, input int md);
    int k;
    sclk = (md != 1);
    #80;
    cs_n = 1'b0;
    if (md == 2) sclk = 1'b0;
    if (md == 0) #80;
    for (k = 0; k < n; k++) begin
      if (k > 0 || md == 0) sclk = 1'b0;
      #80;
      sclk = 1'b1;
      bits.push_back(rx);
      #80;
    end
    cs_n = 1'b1;
    #100;
  endtask
endmodule

// ==== bench/ssar_readout_test.sv ====
`timescale 1ns/1ps
// readout bench top
module ssar_readout_test;
  logic clk = 1'b0; // system clock
  logic sys_rst = 1'b1; // reset
  logic cs_n, sclk, dout_o, dout_oe; // link
  logic [11:0] sample_data = 12'h000; // core word
  logic sample_valid = 1'b0;
  logic sample_ready, track_o, converting_o, conv_done_o, conv_abort_o, underrun_o;
  int error_cnt = 0;
  int checks = 0;
  int n_done = 0, n_abort = 0, n_under = 0; // pulse tallies
  always #2.5 clk = ~clk;
  ssar_readout ssar_readout_i (.clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .dout_o(dout_o), .dout_oe(dout_oe), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .track_o(track_o),
    .converting_o(converting_o), .conv_done_o(conv_done_o),
    .conv_abort_o(conv_abort_o), .underrun_o(underrun_o));
  ssar_host ssar_host_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o),
    .dout_oe(dout_oe));
  // count status pulses
  always @(posedge clk) begin
    if (conv_done_o === 1'b1) n_done++;
    if (conv_abort_o === 1'b1) n_abort++;
    if (underrun_o === 1'b1) n_under++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // assemble n captured bits, zeros first
  task automatic word(input logic [11:0] w, input int n);
    logic [15:0] g;
    g = 16'h0000;
    repeat (n) g = {g[14:0], ssar_host_i.bits.pop_front()};
    chk(g, {4'h0, w} >> (16 - n));
  endtask
  // offer one word; an edge passes first so valid never toggles twice
  task automatic push(input logic [11:0] w);
    int t;
    t = 0;
    @(posedge clk);
    #1;
    sample_data = w;
    sample_valid = 1'b1;
    while (sample_ready !== 1'b1 && t < 9000) begin
      @(posedge clk);
      #1;
      t++;
    end
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
  endtask
  task automatic t_single();
    push(12'h7FF);
    ssar_host_i.frame(16, 0);
    word(12'h7FF, 16);
    chk(16'(n_done), 16'h0001);
    chk({15'h0, dout_oe}, 16'h0000);
  endtask
  task automatic t_cont();
    push(12'h800);
    push(12'h001);
    ssar_host_i.frame(32, 1);
    word(12'h800, 16);
    word(12'h001, 16);
    chk(16'(n_done), 16'h0003);
  endtask
  task automatic t_short();
    push(12'hFFF);
    ssar_host_i.frame(9, 2);
    word(12'hFFF, 9);
    chk(16'(n_abort), 16'h0001);
    chk({15'h0, dout_oe}, 16'h0000);
  endtask
  // fill the buffer, stall, then drain past empty
  task automatic t_fill();
    push(12'hA55);
    push(12'h5AA);
    @(posedge clk);
    #1;
    chk({15'h0, sample_ready}, 16'h0000);
    fork
      push(12'hC3C);
      ssar_host_i.frame(32, 0);
    join
    word(12'hA55, 16);
    word(12'h5AA, 16);
    chk(16'(n_under), 16'h0000);
    ssar_host_i.frame(32, 0);
    word(12'hC3C, 16);
    word(12'hC3C, 16);
    chk(16'(n_under), 16'h0001);
    chk(16'(n_done), 16'h0007);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    t_single();
    t_cont();
    t_short();
    t_fill();
    tally_and_finish();
  end
  // hang guard, well past the expected run
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind ssar_readout ssar_chk ssar_chk_i (.clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
  .sclk_pin(sclk_pin), .dout_o(dout_o), .dout_oe(dout_oe), .sample_data(sample_data),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .track_o(track_o),
  .converting_o(converting_o), .conv_done_o(conv_done_o),
  .conv_abort_o(conv_abort_o), .underrun_o(underrun_o));
